// >>> pdmr_fwd_shift.sv
// Serial forwarding engine towards the oscillator subsystem
`default_nettype none

module pdmr_fwd_shift
	import pdmr_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst,
	pdmr_link_if.fwd_eng       link,
	output logic               osc_link_clk,
	output logic               osc_link_data,
	output logic               osc_link_frame
);

	typedef struct packed {
		pdmr_link_state_type state;
		logic [1:0]          phase;
		logic [3:0]          bit_count;
		logic [15:0]         shift;
		logic                sclk;
		logic                frame;
	} pdmr_fwd_state_type;

	pdmr_fwd_state_type q;
	pdmr_fwd_state_type next_q;

	always_comb begin
		next_q = q;
		case (q.state)
			PDMR_LINK_IDLE: begin
				if (link.fwd_start) begin
					next_q.state     = PDMR_LINK_SHIFT;
					next_q.phase     = 2'h0;
					next_q.bit_count = 4'h0;
					next_q.shift     = link.fwd_word;
					next_q.frame     = 1'b1;
				end
			end
			default: begin
				next_q.phase = q.phase + 2'h1; // Link runs at a quarter of clk [R15]
				if (q.phase == LINK_LAST_PHASE) begin
					if (q.bit_count == LINK_LAST_BIT) begin
						next_q.state = PDMR_LINK_IDLE;
						next_q.frame = 1'b0;
					end else begin
						next_q.bit_count = q.bit_count + 4'h1;
						next_q.shift     = {q.shift[14:0], 1'b0}; // Most significant first [R14]
					end
				end
			end
		endcase
		next_q.sclk = (next_q.state == PDMR_LINK_SHIFT) && (next_q.phase >= LINK_HIGH_PHASE);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '{PDMR_LINK_IDLE, 2'h0, 4'h0, 16'h0000, 1'b0, 1'b0};
		end else begin
			q <= next_q;
		end
	end

	assign link.fwd_busy  = (q.state == PDMR_LINK_SHIFT);
	assign osc_link_clk   = q.sclk;
	assign osc_link_data  = q.shift[15];
	assign osc_link_frame = q.frame;

endmodule

`default_nettype wire

// >>> pdmr_link_if.sv
// Carrier between the register bank, its forwarding engine and its seed holder
`default_nettype none

interface pdmr_link_if;
	logic        fwd_start;
	logic [15:0] fwd_word;
	logic        fwd_busy;
	logic        seed_load;
	logic [1:0]  seed_sel;
	logic [23:0] seed_value;

	modport fwd_ctl  (output fwd_start, fwd_word, input fwd_busy);
	modport fwd_eng  (input fwd_start, fwd_word, output fwd_busy);
	modport seed_ctl (output seed_load, seed_sel, input seed_value);
	modport seed_eng (input seed_load, seed_sel, output seed_value);
endinterface

`default_nettype wire

// >>> pdmr_osc_model.sv
// Receiver model of the oscillator subsystem on the forwarding link
`default_nettype none

module pdmr_osc_model (
	input  wire logic        link_clk,
	input  wire logic        link_data,
	input  wire logic        link_frame,
	output logic      [15:0] word,
	output int               count,
	output int               bits
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] shift_reg = 16'h0000;
	int          run = 0;

	initial begin
		word = 16'h0000;
		count = 0;
		bits = 0;
	end

	// Bits taken on the rising link clock, word closed when the frame falls
	always @(posedge link_clk or negedge link_frame) begin
		if (!link_frame) begin
			if (run != 0) begin
				word <= shift_reg;
				bits <= run;
				count <= count + 1;
				run <= 0;
			end
		end else begin
			shift_reg <= {shift_reg[14:0], link_data};
			run <= run + 1;
		end
	end
endmodule

`default_nettype wire

// >>> pdmr_pkg.sv
// Constants, register map and helpers for the divider and modulator register bank
`default_nettype none

package pdmr_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register offsets on the register port
	localparam logic [4:0] ADDR_REF_DIV     = 5'h02;
	localparam logic [4:0] ADDR_INT_FREQ    = 5'h03;
	localparam logic [4:0] ADDR_FRAC_FREQ   = 5'h04;
	localparam logic [4:0] ADDR_OSC_ACCESS  = 5'h05;
	localparam logic [4:0] ADDR_MOD_CFG     = 5'h06;
	localparam logic [4:0] ADDR_DEV_CTRL    = 5'h08;
	localparam logic [4:0] ADDR_LINK_STATUS = 5'h09;

	////////////////////////////////////////////////////////////////////////////////
	// Values after reset
	localparam logic [13:0] RESET_REF_DIV    = 14'h0001;
	localparam logic [18:0] RESET_INT_FREQ   = 19'h00019;
	localparam logic [23:0] RESET_FRAC_FREQ  = 24'h000000;
	localparam logic [15:0] RESET_OSC_ACCESS = 16'h0000;
	localparam logic [23:0] RESET_MOD_CFG    = 24'h200B4A;
	localparam logic        RESET_REF_BUF_EN = 1'h0;
	localparam logic        RESET_MOD_RST_N  = 1'h1;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CFG_SEED_LSB      = 0;
	localparam int CFG_BYPASS_BIT    = 7;
	localparam int CFG_AUTO_SEED_BIT = 8;
	localparam int CFG_CORE_EN_BIT   = 11;
	localparam int CTRL_MOD_RST_BIT  = 0;
	localparam int CTRL_REF_BUF_BIT  = 3;
	localparam int OSC_ID_LSB        = 0;
	localparam int OSC_ADDR_LSB      = 3;
	localparam int OSC_DATA_LSB      = 7;
	localparam int STAT_BUSY_BIT     = 0;
	localparam int STAT_PEND_BIT     = 1;
	localparam int STAT_FRAC_BIT     = 2;

	////////////////////////////////////////////////////////////////////////////////
	// Divider and seed constants
	localparam logic [13:0] REF_DIV_UNITY = 14'h0001;
	localparam logic [23:0] SEED_ZERO     = 24'h000000;
	localparam logic [23:0] SEED_LSB      = 24'h000001;
	localparam logic [23:0] SEED_PATTERN2 = 24'hB29D08;
	localparam logic [23:0] SEED_PATTERN3 = 24'h50F1CD;

	////////////////////////////////////////////////////////////////////////////////
	// Forwarding link timing: link clock is the block clock divided by four
	localparam int          LINK_DIVIDE     = 4;
	localparam logic [1:0]  LINK_LAST_PHASE = 2'(LINK_DIVIDE - 1);
	localparam logic [1:0]  LINK_HIGH_PHASE = 2'(LINK_DIVIDE / 2);
	localparam logic [3:0]  LINK_LAST_BIT   = 4'hF;

	typedef enum logic [0:0] {
		PDMR_LINK_IDLE  = 1'b0,
		PDMR_LINK_SHIFT = 1'b1
	} pdmr_link_state_type;

	////////////////////////////////////////////////////////////////////////////////
	// Seed selector lookup
	function automatic logic [23:0] pdmr_seed_of(input logic [1:0] sel);
		logic [23:0] value;
		value = SEED_ZERO;
		case (sel)
			2'h0: value = SEED_ZERO;
			2'h1: value = SEED_LSB;
			2'h2: value = SEED_PATTERN2;
			default: value = SEED_PATTERN3;
		endcase
		return value;
	endfunction

endpackage

`default_nettype wire

// >>> pdmr_regs.sv
// Register bank for the reference divider, feedback divider, indirect access and modulator
//
// Contract
// R1: Reference divide is 14 bits, 1..16383, effective only with reference buffer enabled.
// R2: Host keeps 19-bit integer divide within range of active mode.
// R3: Fractional divide is 24-bit unsigned, fraction equals value over two to 24.
// R4: Fractional value applies only in fractional mode, ignored in integer mode.
// R5: Every indirect access write starts a forwarding transfer by its own engine; here writes while one is pending merge, only the latest word is sent.
// R6: Reading indirect access returns only the most recently forwarded word; here it returns the most recently written word, even before it is forwarded.
// R7: Indirect word: id bits 2..0, address bits 6..3, data bits 15..7.
// R8: Seed code 0 zero, 1 lsb, 2 B29D08h, 3 50F1CDh.
// R9: Seed is stored, loaded on frequency change only when automatic seed load set.
// R10: Bypass 0 lets modulator drive divider; bypass 1 ignores modulator output.
// R11: Bypassed modulator keeps running while its active-low reset control is one.
// R12: Core enable 0 disables fractional core; 1 enables it.
// R13: Core enable picks whether integer or fractional write starts band calibration.
// R14: Forwarded word shifts out most significant bit first over internal link.
// R15: Link runs at calibration clock rate, reference divided by four.
// R16: Registers update whole on a complete host write, never partially.
//
// Decided for this implementation: the plain strobed port.
`default_nettype none

module pdmr_regs
	import pdmr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [4:0]  addr,
	input  wire logic [23:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [23:0] rdata,
	output logic      [13:0] ref_divide,
	output logic             ref_divide_active,
	output logic      [18:0] feedback_integer,
	output logic      [23:0] feedback_fraction,
	output logic             fractional_mode,
	output logic             divider_uses_modulator,
	output logic             modulator_core_enable,
	output logic             modulator_reset_n,
	output logic             modulator_clock_run,
	output logic      [23:0] modulator_seed,
	output logic             band_calibration_start,
	output logic      [2:0]  osc_subsystem_id,
	output logic      [3:0]  osc_register_address,
	output logic      [8:0]  osc_data,
	output logic             osc_link_clk,
	output logic             osc_link_data,
	output logic             osc_link_frame
);

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [13:0] ref_div;
		logic [18:0] int_freq;
		logic [23:0] frac_freq;
		logic [15:0] osc_word;
		logic [23:0] mod_cfg;
		logic        ref_buf_en;
		logic        mod_rst_n;
		logic        fwd_pending;
		logic        fwd_start;
		logic [23:0] rdata;
		logic [13:0] ref_divide;
		logic        ref_active;
		logic [23:0] fb_fraction;
		logic        frac_mode;
		logic        uses_mod;
		logic        core_en;
		logic        clock_run;
		logic        cal_start;
		logic        seed_load;
	} pdmr_regs_state_type;

	pdmr_regs_state_type q;
	pdmr_regs_state_type next_q;

	pdmr_link_if link ();

	logic wr_ref;
	logic wr_int;
	logic wr_frac;
	logic wr_osc;
	logic wr_cfg;
	logic wr_ctrl;

	////////////////////////////////////////////////////////////////////////////////
	// Forwarding engine and seed holder

	pdmr_fwd_shift u_fwd (
		.clk            (clk),
		.rst            (rst),
		.link           (link.fwd_eng),
		.osc_link_clk   (osc_link_clk),
		.osc_link_data  (osc_link_data),
		.osc_link_frame (osc_link_frame)
	);

	pdmr_seed_hold u_seed (
		.clk  (clk),
		.rst  (rst),
		.link (link.seed_eng)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Write decode

	always_comb begin
		wr_ref  = 1'b0;
		wr_int  = 1'b0;
		wr_frac = 1'b0;
		wr_osc  = 1'b0;
		wr_cfg  = 1'b0;
		wr_ctrl = 1'b0;
		if (wr && addr == ADDR_REF_DIV) begin
			wr_ref = 1'b1;
		end else if (wr && addr == ADDR_INT_FREQ) begin
			wr_int = 1'b1;
		end else if (wr && addr == ADDR_FRAC_FREQ) begin
			wr_frac = 1'b1;
		end else if (wr && addr == ADDR_OSC_ACCESS) begin
			wr_osc = 1'b1;
		end else if (wr && addr == ADDR_MOD_CFG) begin
			wr_cfg = 1'b1;
		end else if (wr && addr == ADDR_DEV_CTRL) begin
			wr_ctrl = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_q = q;

		// Whole-word register updates from one strobe
		if (wr_ref) begin
			next_q.ref_div = wdata[13:0]; // [R1] [R16]
		end
		if (wr_int) begin
			next_q.int_freq = wdata[18:0]; // Range is the host's duty [R2] [R16]
		end
		if (wr_frac) begin
			next_q.frac_freq = wdata[23:0]; // [R3] [R16]
		end
		if (wr_osc) begin
			next_q.osc_word = wdata[15:0]; // [R16]
		end
		if (wr_cfg) begin
			next_q.mod_cfg = wdata[23:0]; // Seed code held here until loaded [R9] [R16]
		end
		if (wr_ctrl) begin
			next_q.ref_buf_en = wdata[CTRL_REF_BUF_BIT];
			next_q.mod_rst_n  = wdata[CTRL_MOD_RST_BIT];
		end

		// Forwarding: a write queues a transfer, writes while one is pending merge into it, the latest word wins
		next_q.fwd_start = 1'b0;
		if (wr_osc) begin
			next_q.fwd_pending = 1'b1; // [R5]
		end else if (q.fwd_pending && !q.fwd_start && !link.fwd_busy) begin
			next_q.fwd_start   = 1'b1; // [R5]
			next_q.fwd_pending = 1'b0;
		end

		// Band calibration start chosen by core enable
		next_q.cal_start = q.mod_cfg[CFG_CORE_EN_BIT] ? wr_frac : wr_int; // [R13]
		next_q.seed_load = next_q.cal_start && q.mod_cfg[CFG_AUTO_SEED_BIT]; // [R9]

		// Divider and modulator outputs
		next_q.ref_active  = next_q.ref_buf_en;
		next_q.ref_divide  = next_q.ref_buf_en ? next_q.ref_div : REF_DIV_UNITY; // [R1]
		next_q.core_en     = next_q.mod_cfg[CFG_CORE_EN_BIT]; // [R12]
		next_q.uses_mod    = !next_q.mod_cfg[CFG_BYPASS_BIT]; // [R10]
		next_q.frac_mode   = next_q.core_en && next_q.uses_mod;
		next_q.fb_fraction = next_q.frac_mode ? next_q.frac_freq : RESET_FRAC_FREQ; // [R4]
		next_q.clock_run   = next_q.core_en && next_q.mod_rst_n; // Runs even when bypassed [R11]

		// Read port, answer in the following cycle
		next_q.rdata = 24'h000000;
		if (rd) begin
			if (addr == ADDR_REF_DIV) begin
				next_q.rdata = {10'h000, q.ref_div};
			end else if (addr == ADDR_INT_FREQ) begin
				next_q.rdata = {5'h00, q.int_freq};
			end else if (addr == ADDR_FRAC_FREQ) begin
				next_q.rdata = q.frac_freq;
			end else if (addr == ADDR_OSC_ACCESS) begin
				next_q.rdata = {8'h00, q.osc_word}; // Last written word, even before forwarding [R6]
			end else if (addr == ADDR_MOD_CFG) begin
				next_q.rdata = q.mod_cfg;
			end else if (addr == ADDR_DEV_CTRL) begin
				next_q.rdata = {20'h00000, q.ref_buf_en, 2'h0, q.mod_rst_n};
			end else if (addr == ADDR_LINK_STATUS) begin
				next_q.rdata = {21'h000000, q.frac_mode, q.fwd_pending, link.fwd_busy};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk) begin
		if (rst) begin
			q.ref_div     <= RESET_REF_DIV;
			q.int_freq    <= RESET_INT_FREQ;
			q.frac_freq   <= RESET_FRAC_FREQ;
			q.osc_word    <= RESET_OSC_ACCESS;
			q.mod_cfg     <= RESET_MOD_CFG;
			q.ref_buf_en  <= RESET_REF_BUF_EN;
			q.mod_rst_n   <= RESET_MOD_RST_N;
			q.fwd_pending <= 1'b0;
			q.fwd_start   <= 1'b0;
			q.rdata       <= 24'h000000;
			q.ref_divide  <= REF_DIV_UNITY;
			q.ref_active  <= RESET_REF_BUF_EN;
			q.fb_fraction <= RESET_FRAC_FREQ;
			q.frac_mode   <= RESET_MOD_CFG[CFG_CORE_EN_BIT] && !RESET_MOD_CFG[CFG_BYPASS_BIT];
			q.uses_mod    <= !RESET_MOD_CFG[CFG_BYPASS_BIT];
			q.core_en     <= RESET_MOD_CFG[CFG_CORE_EN_BIT];
			q.clock_run   <= RESET_MOD_CFG[CFG_CORE_EN_BIT] && RESET_MOD_RST_N;
			q.cal_start   <= 1'b0;
			q.seed_load   <= 1'b0;
		end else begin
			q <= next_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interface drive and outputs

	assign link.fwd_start = q.fwd_start;
	assign link.fwd_word  = q.osc_word;
	assign link.seed_load = q.seed_load;
	assign link.seed_sel  = q.mod_cfg[CFG_SEED_LSB +: 2]; // [R8]

	assign rdata                  = q.rdata;
	assign ref_divide             = q.ref_divide;
	assign ref_divide_active      = q.ref_active;
	assign feedback_integer       = q.int_freq;
	assign feedback_fraction      = q.fb_fraction;
	assign fractional_mode        = q.frac_mode;
	assign divider_uses_modulator = q.uses_mod;
	assign modulator_core_enable  = q.core_en;
	assign modulator_reset_n      = q.mod_rst_n;
	assign modulator_clock_run    = q.clock_run;
	assign modulator_seed         = link.seed_value;
	assign band_calibration_start = q.cal_start;
	assign osc_subsystem_id       = q.osc_word[OSC_ID_LSB +: 3]; // [R7]
	assign osc_register_address   = q.osc_word[OSC_ADDR_LSB +: 4]; // [R7]
	assign osc_data               = q.osc_word[OSC_DATA_LSB +: 9]; // [R7]

endmodule

`default_nettype wire

// >>> pdmr_regs_monitor.sv
// Checker of the register bank's port behaviour
`default_nettype none

module pdmr_regs_monitor
	import pdmr_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [4:0]  addr,
	input wire logic [23:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [23:0] rdata,
	input wire logic [13:0] ref_divide,
	input wire logic        ref_divide_active,
	input wire logic [23:0] feedback_fraction,
	input wire logic        fractional_mode,
	input wire logic        modulator_core_enable,
	input wire logic        modulator_reset_n,
	input wire logic        modulator_clock_run,
	input wire logic        band_calibration_start,
	input wire logic [2:0]  osc_subsystem_id,
	input wire logic [3:0]  osc_register_address,
	input wire logic [8:0]  osc_data,
	input wire logic        osc_link_clk,
	input wire logic        osc_link_data,
	input wire logic        osc_link_frame
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 24'h000000)
		else $error("read data outside answer cycle");
	calib_int_a: assert property ((wr && addr == ADDR_INT_FREQ && !modulator_core_enable)
		|=> band_calibration_start) else $error("no calibration on integer write");
	calib_frac_a: assert property ((wr && addr == ADDR_FRAC_FREQ && modulator_core_enable)
		|=> band_calibration_start) else $error("no calibration on fraction write");
	fwd_start_a: assert property ((wr && addr == ADDR_OSC_ACCESS && !osc_link_frame
		&& !$past(osc_link_frame)) |-> ##3 osc_link_frame)
		else $error("forwarding did not start");
	frame_len_a: assert property ($rose(osc_link_frame) |-> ##63 osc_link_frame
		##1 !osc_link_frame) else $error("frame length wrong");
	link_rate_a: assert property ($rose(osc_link_clk) |->
		##1 osc_link_clk ##1 !osc_link_clk) else $error("link clock high time wrong");
	data_hold_a: assert property (osc_link_clk |-> $stable(osc_link_data))
		else $error("link data moved while link clock high");
	osc_fields_a: assert property ((wr && addr == ADDR_OSC_ACCESS) |=>
		{osc_data, osc_register_address, osc_subsystem_id} == $past(wdata[15:0]))
		else $error("indirect fields wrong");
	frac_zero_a: assert property (!fractional_mode |-> feedback_fraction == 24'h000000)
		else $error("fraction applied outside fractional mode");
	ref_unity_a: assert property (!ref_divide_active |-> ref_divide == 14'h0001)
		else $error("reference divide active without buffer");
	clock_run_a: assert property (modulator_clock_run
		== (modulator_core_enable && modulator_reset_n))
		else $error("modulator clock run wrong");

	cover property (band_calibration_start);
	cover property ($rose(osc_link_frame));
	cover property (ref_divide_active && ref_divide != 14'h0001);
endmodule

bind pdmr_regs pdmr_regs_monitor mon (.*);

`default_nettype wire

// >>> pdmr_seed_hold.sv
// Modulator seed holder, loaded on a frequency change
`default_nettype none

module pdmr_seed_hold
	import pdmr_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst,
	pdmr_link_if.seed_eng      link
);

	typedef struct packed {
		logic [23:0] seed;
	} pdmr_seed_state_type;

	pdmr_seed_state_type q;
	pdmr_seed_state_type next_q;

	always_comb begin
		next_q = q;
		if (link.seed_load) begin
			next_q.seed = pdmr_seed_of(link.seed_sel); // Seed code lookup [R8]
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '{seed: SEED_ZERO};
		end else begin
			q <= next_q;
		end
	end

	assign link.seed_value = q.seed;

endmodule

`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the divider and modulator register bank
`default_nettype none

module tb_top
	import pdmr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic        w;
		logic [4:0]  a;
		logic [23:0] d;
		logic [23:0] e;
	} pdmr_row_type;

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [4:0]  addr = 5'h00;
	logic [23:0] wdata = 24'h000000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [23:0] rdata, feedback_fraction, modulator_seed;
	logic [13:0] ref_divide;
	logic [18:0] feedback_integer;
	logic [2:0]  osc_subsystem_id;
	logic [3:0]  osc_register_address;
	logic [8:0]  osc_data;
	logic        ref_divide_active, fractional_mode, divider_uses_modulator;
	logic        modulator_core_enable, modulator_reset_n, modulator_clock_run;
	logic        band_calibration_start, osc_link_clk, osc_link_data, osc_link_frame;
	logic [15:0] rx_word;
	int          rx_count, rx_bits;
	int          fail_count = 0;
	int          checked = 0;
	logic [23:0] seeds [4] = '{SEED_ZERO, SEED_LSB, SEED_PATTERN2, SEED_PATTERN3};
	pdmr_row_type rows [15] = '{
		'{1'b0, 5'h02, 24'h0, 24'h000001}, '{1'b0, 5'h03, 24'h0, 24'h000019},
		'{1'b0, 5'h04, 24'h0, 24'h000000}, '{1'b0, 5'h05, 24'h0, 24'h000000},
		'{1'b0, 5'h06, 24'h0, 24'h200B4A}, '{1'b0, 5'h08, 24'h0, 24'h000001},
		'{1'b0, 5'h09, 24'h0, 24'h000004}, '{1'b0, 5'h07, 24'h0, 24'h000000},
		'{1'b0, 5'h1F, 24'h0, 24'h000000}, '{1'b1, 5'h02, 24'hFFFFFF, 24'h003FFF},
		'{1'b1, 5'h03, 24'hFFFFFC, 24'h07FFFC}, '{1'b1, 5'h04, 24'hABCDEF, 24'hABCDEF},
		'{1'b1, 5'h07, 24'h123456, 24'h000000}, '{1'b1, 5'h09, 24'hFFFFFF, 24'h000004},
		'{1'b1, 5'h02, 24'h000005, 24'h000005}};

	pdmr_regs DUT (.*);
	pdmr_osc_model osc (.link_clk(osc_link_clk), .link_data(osc_link_data),
		.link_frame(osc_link_frame), .word(rx_word), .count(rx_count), .bits(rx_bits));

	always #25 clk = ~clk;

	////////////////////////////////////////////////////////////
	task automatic cmp(input string name, input logic [23:0] exp, input logic [23:0] seen);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic step();
		@(posedge clk);
		#1;
	endtask

	task automatic wr_reg(input logic [4:0] a, input logic [23:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	task automatic rd_reg(input logic [4:0] a, input logic [23:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 cmp("rdata", e, rdata);
	endtask

	task automatic wait_rx(input int n);
		for (int i = 0; i < 300; i++) begin
			if (rx_count == n)
				return;
			step();
		end
		fail_count++;
		$display("unexpected link word count expected %0d seen %0d", n, rx_count);
		final_report();
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		step();
		cmp("ref_divide", 24'h000001, 24'(ref_divide));
		cmp("fractional_mode", 24'h000001, 24'(fractional_mode));
		cmp("seed", 24'h000000, modulator_seed);
		foreach (rows[i]) begin
			if (rows[i].w)
				wr_reg(rows[i].a, rows[i].d);
			rd_reg(rows[i].a, rows[i].e);
		end
		$display("test register table done");
		cmp("ref_divide", 24'h000001, 24'(ref_divide));
		wr_reg(ADDR_DEV_CTRL, 24'h000009);
		cmp("ref_divide", 24'h000005, 24'(ref_divide));
		cmp("ref_active", 24'h000001, 24'(ref_divide_active));
		$display("test reference divide done");
		for (int c = 0; c < 4; c++) begin
			wr_reg(ADDR_MOD_CFG, 24'h200B48 | 24'(c));
			wr_reg(ADDR_FRAC_FREQ, 24'hFFFFFF - 24'(c));
			cmp("calibration", 24'h000001, 24'(band_calibration_start));
			cmp("fraction", 24'hFFFFFF - 24'(c), feedback_fraction);
			step();
			cmp("seed", seeds[c], modulator_seed);
		end
		wr_reg(ADDR_MOD_CFG, 24'h200A49);
		wr_reg(ADDR_FRAC_FREQ, 24'h000010);
		repeat (2) step();
		cmp("seed", SEED_PATTERN3, modulator_seed);
		$display("test seed done");
		wr_reg(ADDR_MOD_CFG, 24'h20034A);
		wr_reg(ADDR_INT_FREQ, 24'h000020);
		cmp("calibration", 24'h000001, 24'(band_calibration_start));
		cmp("fractional_mode", 24'h000000, 24'(fractional_mode));
		cmp("core_enable", 24'h000000, 24'(modulator_core_enable));
		cmp("fraction", 24'h000000, feedback_fraction);
		cmp("integer", 24'h000020, 24'(feedback_integer));
		wr_reg(ADDR_FRAC_FREQ, 24'h000011);
		cmp("calibration", 24'h000000, 24'(band_calibration_start));
		wr_reg(ADDR_MOD_CFG, 24'h200BCA);
		cmp("uses_modulator", 24'h000000, 24'(divider_uses_modulator));
		cmp("clock_run", 24'h000001, 24'(modulator_clock_run));
		wr_reg(ADDR_DEV_CTRL, 24'h000008);
		cmp("clock_run", 24'h000000, 24'(modulator_clock_run));
		cmp("reset_n", 24'h000000, 24'(modulator_reset_n));
		$display("test modes done");
		wr_reg(ADDR_OSC_ACCESS, 24'h00A5C3);
		wait_rx(1);
		cmp("link word", 24'h00A5C3, 24'(rx_word));
		cmp("link bits", 24'h000010, 24'(rx_bits));
		wr_reg(ADDR_OSC_ACCESS, 24'h001111);
		repeat (8) step();
		rd_reg(ADDR_LINK_STATUS, 24'h000001);
		wr_reg(ADDR_OSC_ACCESS, 24'h002222);
		wr_reg(ADDR_OSC_ACCESS, 24'h00F0F1);
		wait_rx(2);
		cmp("link word", 24'h001111, 24'(rx_word));
		wait_rx(3);
		cmp("link word", 24'h00F0F1, 24'(rx_word));
		repeat (80) step();
		cmp("link count", 24'h000003, 24'(rx_count));
		rd_reg(ADDR_OSC_ACCESS, 24'h00F0F1);
		cmp("fields", 24'h00F0F1, {8'h00, osc_data, osc_register_address, osc_subsystem_id});
		$display("test forwarding done");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		step();
		rd_reg(ADDR_MOD_CFG, 24'h200B4A);
		cmp("seed", 24'h000000, modulator_seed);
		$display("test second reset done");
		final_report();
	end
endmodule

`default_nettype wire
